// ===== rtl/tcst_pkg.sv
package tcst_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned T_OFF_US = 10;
  localparam int unsigned T_ON_MS = 1;
  localparam int unsigned T_INIT_MS = 300;
  localparam int unsigned T_FAULT_US = 100;
  localparam int unsigned T_RESET_US = 10;
  localparam int unsigned T_LOSS_US = 100;
  localparam int unsigned T_SOFT_MS = 100;
  localparam int unsigned T_DATA_MS = 1000;
  localparam int unsigned T_SERIAL_MS = 300;
  localparam int unsigned T_WRITE_MS = 10;
  localparam int unsigned F_SERIAL_KHZ = 400;

  // longest times round down, least times round up
  localparam int unsigned OFF_CYC = (T_OFF_US * 1000) / CLK_NS;
  localparam int unsigned RESET_CYC = (T_RESET_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FAULT_CYC = (T_FAULT_US * 1000) / CLK_NS;
  localparam int unsigned LOSS_CYC = (T_LOSS_US * 1000) / CLK_NS;
  localparam int unsigned ON_CYC = (T_ON_MS * 1000_000) / CLK_NS;
  localparam int unsigned INIT_CYC = (T_INIT_MS * 1000_000) / CLK_NS;
  localparam int unsigned DATA_CYC = (T_DATA_MS * 1000_000) / CLK_NS;

  // ==========================================================
  // register map (byte addresses, 32-bit words)
  // ==========================================================
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;

  // diagnostic status byte fields
  localparam int unsigned BIT_SOFT_OFF = 6;
  localparam int unsigned BIT_TX_FAULT = 2;
  localparam int unsigned BIT_RX_LOST = 1;
  localparam int unsigned BIT_MON_RDY = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ==========================================================
  // transmitter state
  // ==========================================================
  typedef enum logic [3:0] {
    TCST_INIT = 4'b0001,
    TCST_ON = 4'b0010,
    TCST_OFF = 4'b0100,
    TCST_FAULT = 4'b1000
  } tcst_tx_e;

endpackage : tcst_pkg

// ===== rtl/tcst_ctrl.sv
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Requirements
// RQ1: pin high turns laser off quickly
// RQ2: pin low restores modulated output within 1ms
// RQ3: init ends within 300ms, clearing fault
// RQ4: hardware fault output follows fault within 100us; code raises tx_fault only from TCST_ON
// RQ5: pin high 10us clears latched fault shutdown
// RQ6: signal lost raises lost output quickly
// RQ7: signal back drops lost output quickly
// RQ8: soft off bit disables laser
// RQ9: clearing soft off bit restores output
// RQ10: soft fault bit follows fault; it reads tx_fault, which is set only when TCST_ON finds the fault latched
// RQ11: soft lost bit set on signal loss
// RQ12: soft lost bit cleared on return
// RQ13: monitor ready bit set after 1000ms
// RQ14: serial access accepted after power-on delay
// RQ15: writes complete within write cycle time
// RQ16: host keeps serial clock at 400kHz
// RQ17: laser off when pin or soft bit set
module tcst_ctrl #(
  parameter int unsigned ON_CYCLES = tcst_pkg::ON_CYC,
  parameter int unsigned INIT_CYCLES = tcst_pkg::INIT_CYC,
  parameter int unsigned DATA_CYCLES = tcst_pkg::DATA_CYC
) (
  input wire logic clock,
  input wire logic rst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins and laser-side sense inputs
  input wire logic tx_disable_pin,
  input wire logic laser_fault_in,
  input wire logic signal_detect_in,
  output logic laser_enable,
  output logic tx_fault,
  output logic receive_signal_lost,
  output logic serial_ready
);
  import tcst_pkg::*;

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [1:0] dis_sync;
    logic [1:0] flt_sync;
    logic [1:0] sd_sync;
    logic dis_prev;
    tcst_tx_e tx;
    logic [31:0] cnt;
    logic [31:0] hi_cnt;
    logic [31:0] up_cnt;
    logic soft_off;
    logic latched;
    logic laser_en;
    logic tx_fault;
    logic rx_lost;
    logic mon_rdy;
    logic ser_rdy;
    logic ack;
    logic [31:0] rdata;
  } tcst_state_s;

  tcst_state_s st_r;
  tcst_state_s st_nxt;
  logic dis_now;
  logic flt_now;
  logic sd_now;
  logic req;

  // saturating add used by every timer
  function automatic logic [31:0] tcst_inc(input logic [31:0] v);
    tcst_inc = (v == 32'hffffffff) ? v : v + 32'h00000001;
  endfunction : tcst_inc

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    st_nxt = st_r;
    // two flops per asynchronous input
    st_nxt.dis_sync = {st_r.dis_sync[0], tx_disable_pin};
    st_nxt.flt_sync = {st_r.flt_sync[0], laser_fault_in};
    st_nxt.sd_sync = {st_r.sd_sync[0], signal_detect_in};
    dis_now = st_r.dis_sync[1];
    flt_now = st_r.flt_sync[1];
    sd_now = st_r.sd_sync[1];
    st_nxt.dis_prev = dis_now;

    // power-on readiness timers
    st_nxt.up_cnt = tcst_inc(st_r.up_cnt);
    if (st_r.up_cnt >= 32'(INIT_CYCLES)) begin
      st_nxt.ser_rdy = 1'b1; // RQ14
    end
    if (st_r.up_cnt >= 32'(DATA_CYCLES)) begin
      st_nxt.mon_rdy = 1'b1; // RQ13
    end

    // pin high time, for fault clearing
    st_nxt.hi_cnt = dis_now ? tcst_inc(st_r.hi_cnt) : 32'h0;
    if (dis_now && st_r.hi_cnt >= 32'(RESET_CYC - 1)) begin
      st_nxt.latched = 1'b0; // RQ5
    end

    // fault latches; a new fault beats the clear
    if (flt_now && st_r.tx != TCST_INIT) begin
      st_nxt.latched = 1'b1;
    end

    // loss of signal follows detect, well inside 100us
    st_nxt.rx_lost = ~sd_now; // RQ6 RQ7 RQ11 RQ12

    // transmitter sequencing
    st_nxt.cnt = tcst_inc(st_r.cnt);
    unique case (st_r.tx)
      TCST_INIT: begin
        st_nxt.laser_en = 1'b0;
        st_nxt.tx_fault = 1'b0; // RQ3
        if (dis_now || st_r.soft_off) begin
          st_nxt.tx = TCST_OFF; // RQ17
        end else if (st_r.cnt >= 32'(ON_CYCLES)) begin
          // modulated output back well inside 300ms init
          st_nxt.tx = TCST_ON; // RQ2 RQ3 RQ9
          st_nxt.laser_en = 1'b1;
        end
      end
      TCST_ON: begin
        if (st_nxt.latched) begin
          st_nxt.tx = TCST_FAULT;
          st_nxt.laser_en = 1'b0;
          st_nxt.tx_fault = 1'b1; // RQ4 RQ10
        end else if (dis_now || st_r.soft_off) begin
          st_nxt.tx = TCST_OFF;
          st_nxt.laser_en = 1'b0; // RQ1 RQ8 RQ17
        end
      end
      TCST_OFF: begin
        st_nxt.laser_en = 1'b0;
        if (!dis_now && !st_r.soft_off) begin
          st_nxt.tx = TCST_INIT;
          st_nxt.cnt = 32'h0;
        end
      end
      TCST_FAULT: begin
        // fault shutdown holds until a long enough pin pulse
        st_nxt.laser_en = 1'b0;
        st_nxt.tx_fault = 1'b1;
        if (!st_r.latched && !dis_now && st_r.dis_prev) begin
          st_nxt.tx = TCST_INIT; // RQ5
          st_nxt.cnt = 32'h0;
        end
      end
      default: begin
        st_nxt.tx = TCST_INIT;
        st_nxt.cnt = 32'h0;
      end
    endcase

    // wishbone: ack one cycle after strobe, drop next cycle
    req = wb_cyc_i && wb_stb_i && !st_r.ack;
    st_nxt.ack = req;
    st_nxt.rdata = 32'h0;
    if (req) begin
      if (wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
        // write takes effect at once, inside the write cycle
        st_nxt.soft_off = wb_dat_i[BIT_SOFT_OFF]; // RQ8 RQ9 RQ15
      end
      if (!wb_we_i) begin
        unique case (wb_adr_i)
          ADDR_STATUS: begin
            st_nxt.rdata[BIT_SOFT_OFF] = st_r.soft_off | dis_now;
            st_nxt.rdata[BIT_TX_FAULT] = st_r.tx_fault; // RQ10
            st_nxt.rdata[BIT_RX_LOST] = st_r.rx_lost; // RQ11 RQ12
            st_nxt.rdata[BIT_MON_RDY] = st_r.mon_rdy; // RQ13
          end
          ADDR_CTRL: begin
            st_nxt.rdata[BIT_SOFT_OFF] = st_r.soft_off;
          end
          default: begin
            st_nxt.rdata = 32'h0; // unmapped reads zero
          end
        endcase
      end
    end
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
      st_r.tx <= TCST_INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign wb_dat_o = st_r.rdata;
  assign wb_ack_o = st_r.ack;
  assign laser_enable = st_r.laser_en;
  assign tx_fault = st_r.tx_fault;
  assign receive_signal_lost = st_r.rx_lost;
  assign serial_ready = st_r.ser_rdy;

endmodule : tcst_ctrl

// ===== verif/tcst_ctrl_props.sv
`timescale 1ns/1ps
// ====================
// timing checks
module tcst_ctrl_props #(
  parameter int unsigned INIT_CYCLES = 50
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tx_disable_pin,
  input wire logic laser_fault_in,
  input wire logic signal_detect_in,
  input wire logic laser_enable,
  input wire logic tx_fault,
  input wire logic serial_ready,
  input wire logic receive_signal_lost
);
  logic [7:0] hi_r;
  logic [31:0] up_r;
  // pin-high run length, saturating so long runs never wrap, and age since reset, which does not saturate
  always_ff @(posedge clock) begin
    hi_r <= !tx_disable_pin ? 8'h00 : (hi_r == 8'hff ? hi_r : hi_r + 8'h01);
    up_r <= rst ? 32'h0 : up_r + 32'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  off_fast_a: assert property ($rose(tx_disable_pin) |-> ##[1:100] !laser_enable)
    else $error("slow off");
  pin_dark_a: assert property (tx_disable_pin [*8] |-> !laser_enable)
    else $error("lit with pin");
  fault_out_a: assert property (laser_fault_in && laser_enable |-> ##[1:1000] tx_fault)
    else $error("no fault out");
  fault_dark_a: assert property (tx_fault [*8] |-> !laser_enable)
    else $error("lit in fault");
  los_on_a: assert property ($fell(signal_detect_in) |-> ##[1:1000] receive_signal_lost)
    else $error("lost late");
  los_off_a: assert property ($rose(signal_detect_in) |-> ##[1:1000] !receive_signal_lost)
    else $error("back late");
  fault_clear_a: assert property (
    $fell(tx_disable_pin) && hi_r >= 8'h6e && !laser_fault_in |-> ##[1:10] !tx_fault) else $error("not cleared");
  fault_keep_a: assert property (
    $fell(tx_disable_pin) && hi_r < 8'h5a && tx_fault |-> ##1 tx_fault [*8]) else $error("cleared early");
  bus_ready_a: assert property (up_r == INIT_CYCLES + 8 |-> serial_ready)
    else $error("bus not ready");
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
endmodule : tcst_ctrl_props

bind tcst_ctrl tcst_ctrl_props #(.INIT_CYCLES(INIT_CYCLES)) chk (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .tx_disable_pin, .laser_fault_in, .signal_detect_in, .laser_enable, .tx_fault, .serial_ready, .receive_signal_lost);

// ===== verif/tcst_host.sv
`timescale 1ns/1ps
// ====================
// host side of the transmit-off pin
module tcst_host (
  input wire logic clock,
  output logic tx_disable_pin
);
  initial tx_disable_pin = 1'b0;
  // a clearing pulse needs at least 100 edges high; shorter ones probe the latch
  task automatic pulse(input int n);
    tx_disable_pin <= 1'b1;
    repeat (n) @(posedge clock);
    tx_disable_pin <= 1'b0;
  endtask : pulse
endmodule : tcst_host

// ===== verif/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
// ====================
// bench top
module tb;
  import tcst_pkg::*;
  localparam int unsigned ON = 20;
  logic clock = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic laser_fault_in = 1'b0, signal_detect_in = 1'b1, tx_disable_pin;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, laser_enable, tx_fault, receive_signal_lost, serial_ready;
  int miscompares = 0, n_compared = 0;
  always #50 clock = ~clock;
  tcst_host host (.clock, .tx_disable_pin);
  tcst_ctrl #(.ON_CYCLES(ON), .INIT_CYCLES(50), .DATA_CYCLES(80)) dut (.clock, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_disable_pin, .laser_fault_in,
    .signal_detect_in, .laser_enable, .tx_fault, .receive_signal_lost, .serial_ready);
  task automatic tally_and_finish;
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // one classic cycle; no latency assumed, the watchdog ends a hang
  // host paces each access on the slave's own ack, never faster
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb
  task automatic stat(input logic [31:0] e);
    wb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("status", e, q)
  endtask : stat
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (100) @(posedge clock);
    `CHK("ready", 1'b1, serial_ready)
    `CHK("lit", 1'b1, laser_enable)
    stat(32'h1);
    wb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, q)
    wb(1'b1, ADDR_CTRL, 32'h40);
    repeat (8) @(posedge clock);
    `CHK("soft off", 1'b0, laser_enable)
    stat(32'h41);
    wb(1'b1, ADDR_CTRL, 32'h0);
    repeat (ON + 10) @(posedge clock);
    `CHK("soft on", 1'b1, laser_enable)
    signal_detect_in <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK("lost", 1'b1, receive_signal_lost)
    stat(32'h3);
    signal_detect_in <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK("back", 1'b0, receive_signal_lost)
    stat(32'h1);
    laser_fault_in <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK("fault", 1'b1, tx_fault)
    stat(32'h5);
    laser_fault_in <= 1'b0;
    host.pulse(50);
    repeat (8) @(posedge clock);
    `CHK("kept", 1'b1, tx_fault)
    host.pulse(120);
    repeat (ON + 10) @(posedge clock);
    `CHK("cleared", 1'b0, tx_fault)
    `CHK("relit", 1'b1, laser_enable)
    tally_and_finish();
  end
  // the run needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end
endmodule : tb
